// [src/cms_defines.vh]
// constants for the charge mode switch sequencer
// assumes a 250 MHz ref_clk_i; only the 1 ms tick is derived to a cycle count here, other times stay in ms or s
// Operation
// - on position runs inverter, lights inverter-on
// - good mains: pass through, charge, show phase
// - rejected mains starts the inverter
// - charger-only never starts the inverter
// - equalise one hour at raised target
// - equalise current limited to one quarter
// - equalise blinks bulk and absorption
// - forced absorption for configured maximum time
// - sequence only with all selectors on
// - toggle timing half to two seconds
// - off seen restarts the sequence
// - five flashes of three charge lights
// - scan three lights, two seconds each
// - on during bulk light selects equalise
// - on during absorption light selects forced absorption
// - on after scan selects float
// - no move keeps charger-only, float
// - one quick toggle afterwards changes nothing
// - pass-through lights only active phase light
// - ramp-limited bulk lights bulk and absorption
// - current at limit: zero charge, blink mains
`ifndef CMS_DEFINES_VH
`define CMS_DEFINES_VH
`define CMS_CLK_MHZ        250
`define CMS_TICK_US        1000
`define CMS_TICK_CYC       (`CMS_TICK_US * `CMS_CLK_MHZ)
`define CMS_HOLD_MIN_MS    500
`define CMS_HOLD_MAX_MS    2000
`define CMS_SCAN_STEP_MS   2000
`define CMS_FLASH_HALF_MS  250
`define CMS_FLASH_COUNT    5
`define CMS_BLINK_HALF_MS  500
`define CMS_DEBOUNCE_MS    20
`define CMS_TOGGLE_MAX_MS  2000
`define CMS_EQ_TIME_S      3600
`define CMS_EQ_TIME_MS     (`CMS_EQ_TIME_S * 1000)
// arbitrary default, the real limit is set per installation
`define CMS_ABS_MAX_MS     28800000
`define CMS_SEL_OFF        2'h0
`define CMS_SEL_ON         2'h1
`define CMS_SEL_CHG        2'h2
`define CMS_PH_BULK        2'h0
`define CMS_PH_ABS         2'h1
`define CMS_PH_FLOAT       2'h2
`define CMS_MODE_NORMAL    2'h0
`define CMS_MODE_EQ        2'h1
`define CMS_MODE_FABS      2'h2
`define CMS_MODE_FLOAT     2'h3
`endif

// [src/cms_sel_filter.v]
// selector debounce for one three-position switch
// assumes sel_i is asynchronous to ref_clk_i; tick_i is a 1 ms enable
`timescale 1ns/10ps
`default_nettype none
`include "cms_defines.vh"
module cms_sel_filter #(
	parameter DB_MS = `CMS_DEBOUNCE_MS
) (
	input  wire       ref_clk_i,
	input  wire       rst_n_i,
	input  wire       tick_i,
	input  wire [1:0] sel_i,
	output reg  [1:0] sel_o
);
	reg [1:0] meta_reg;
	reg [1:0] sync_reg;
	reg [1:0] cand_reg;
	reg [7:0] cnt_reg;
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			meta_reg <= `CMS_SEL_ON;
			sync_reg <= `CMS_SEL_ON;
			cand_reg <= `CMS_SEL_ON;
			cnt_reg  <= 8'h00;
			sel_o    <= `CMS_SEL_ON;
		end else begin
			meta_reg <= sel_i;
			sync_reg <= meta_reg;
			// off is passed at once so a brief off is never masked
			if (sync_reg != cand_reg) begin
				cand_reg <= sync_reg;
				cnt_reg  <= 8'h00;
				if (sync_reg == `CMS_SEL_OFF)
					sel_o <= `CMS_SEL_OFF;
			end else if (tick_i) begin
				if (cnt_reg == DB_MS[7:0] - 8'h01)
					sel_o <= cand_reg;
				else
					cnt_reg <= cnt_reg + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// [src/cms_sequencer.v]
// switch sequencer, power path control and status lights
// assumes mains_ok_i, phase, ramp and limit come from same-clock logic
// front and remote selectors are pins; remote_present_i is a strap level
`timescale 1ns/10ps
`default_nettype none
`include "cms_defines.vh"
module cms_sequencer #(
	parameter TICK_CYC   = `CMS_TICK_CYC,
	parameter EQ_MS      = `CMS_EQ_TIME_MS,
	parameter ABS_MAX_MS = `CMS_ABS_MAX_MS
) (
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	input  wire [1:0]  front_sel_i,
	input  wire [1:0]  remote_sel_i,
	input  wire        remote_present_i,
	input  wire        mains_ok_i,
	input  wire [1:0]  charge_phase_i,
	input  wire        ramp_limited_i,
	input  wire        in_limit_i,
	input  wire        batt_24v_i,
	output reg         power_en_o,
	output reg         inverter_en_o,
	output reg         pass_through_o,
	output reg         charger_en_o,
	output reg  [1:0]  charge_mode_o,
	output reg  [1:0]  target_raise_v_o,
	output reg         current_quarter_o,
	output reg         current_zero_o,
	output reg         led_inverter_o,
	output reg         led_mains_o,
	output reg         led_bulk_o,
	output reg         led_abs_o,
	output reg         led_float_o
);
	localparam S_IDLE  = 7'h01;
	localparam S_HOLD1 = 7'h02;
	localparam S_HOLD2 = 7'h04;
	localparam S_ARM   = 7'h08;
	localparam S_FLASH = 7'h10;
	localparam S_SCAN  = 7'h20;
	localparam S_DONE  = 7'h40;
	// header counts widened once so narrow counters compare on purpose
	localparam [31:0] FLASH_STEPS = 2 * `CMS_FLASH_COUNT;
	localparam [31:0] BLINK_LAST  = `CMS_BLINK_HALF_MS - 1;

	reg  [31:0] div_reg;
	reg         tick_reg;
	reg  [31:0] ms_reg;
	reg  [6:0]  st_reg;
	reg  [6:0]  st_next;
	reg  [31:0] tmr_reg;
	reg  [3:0]  step_reg;
	reg  [1:0]  mode_reg;
	reg  [31:0] mode_tmr_reg;
	reg  [9:0]  blink_reg;
	reg         blink_reg_q;
	reg         rp_meta_reg;
	reg         rp_reg;
	reg  [1:0]  eff_prev_reg;
	reg  [31:0] tog_reg;
	reg         tog_armed_reg;
	wire [1:0]  front_f;
	wire [1:0]  remote_f;
	reg  [1:0]  eff;
	reg         all_on;
	wire        flash_lit;

	// true when a hold time lies inside the half to two second window
	function in_window;
		input [31:0] t;
		begin
			in_window = (t >= `CMS_HOLD_MIN_MS) && (t <= `CMS_HOLD_MAX_MS);
		end
	endfunction

	// the step that ends the flashes stays dark, else a sixth blip shows
	assign flash_lit = ~step_reg[0] && ({28'h0, step_reg} < FLASH_STEPS);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			div_reg  <= 32'h0;
			tick_reg <= 1'b0;
		end else if (div_reg == TICK_CYC - 1) begin
			div_reg  <= 32'h0;
			tick_reg <= 1'b1;
		end else begin
			div_reg  <= div_reg + 32'h1;
			tick_reg <= 1'b0;
		end
	end

	cms_sel_filter u_front (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.tick_i    (tick_reg),
		.sel_i     (front_sel_i),
		.sel_o     (front_f)
	);
	cms_sel_filter u_remote (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.tick_i    (tick_reg),
		.sel_i     (remote_sel_i),
		.sel_o     (remote_f)
	);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rp_meta_reg <= 1'b0;
			rp_reg      <= 1'b0;
		end else begin
			rp_meta_reg <= remote_present_i;
			rp_reg      <= rp_meta_reg;
		end
	end

	// combined selector: any off wins, then any charger-only
	always @* begin
		all_on = (front_f == `CMS_SEL_ON) && (!rp_reg || remote_f == `CMS_SEL_ON);
		if (front_f == `CMS_SEL_OFF || (rp_reg && remote_f == `CMS_SEL_OFF))
			eff = `CMS_SEL_OFF;
		else if (front_f == `CMS_SEL_CHG || (rp_reg && remote_f == `CMS_SEL_CHG))
			eff = `CMS_SEL_CHG;
		else
			eff = `CMS_SEL_ON;
	end

	// sequence detector
	always @* begin
		st_next = st_reg;
		case (st_reg)
		S_IDLE: begin
			// operator is trusted to start only from float
			// a correction toggle right after a selection never restarts it
			if (eff_prev_reg == `CMS_SEL_ON && eff == `CMS_SEL_CHG && !tog_armed_reg)
				st_next = S_HOLD1;
		end
		S_HOLD1: begin
			if (eff == `CMS_SEL_OFF || tmr_reg > `CMS_HOLD_MAX_MS)
				st_next = S_IDLE;
			else if (all_on)
				st_next = in_window(tmr_reg) ? S_HOLD2 : S_IDLE;
		end
		S_HOLD2: begin
			if (eff == `CMS_SEL_OFF || tmr_reg > `CMS_HOLD_MAX_MS)
				st_next = S_IDLE;
			else if (eff == `CMS_SEL_CHG)
				st_next = in_window(tmr_reg) ? S_ARM : S_IDLE;
		end
		S_ARM: begin
			if (eff != `CMS_SEL_CHG)
				st_next = S_IDLE;
			else if (tmr_reg >= `CMS_HOLD_MIN_MS)
				st_next = S_FLASH;
		end
		S_FLASH: begin
			if (eff == `CMS_SEL_OFF)
				st_next = S_IDLE;
			else if ({28'h0, step_reg} == FLASH_STEPS)
				st_next = S_SCAN;
		end
		S_SCAN: begin
			if (eff == `CMS_SEL_OFF)
				st_next = S_IDLE;
			else if (eff == `CMS_SEL_ON || step_reg == 4'h3)
				st_next = S_DONE;
		end
		S_DONE: st_next = S_IDLE;
		default: st_next = S_IDLE;
		endcase
	end

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_reg        <= S_IDLE;
			tmr_reg       <= 32'h0;
			step_reg      <= 4'h0;
			mode_reg      <= `CMS_MODE_NORMAL;
			mode_tmr_reg  <= 32'h0;
			eff_prev_reg  <= `CMS_SEL_ON;
			tog_reg       <= 32'h0;
			tog_armed_reg <= 1'b0;
			blink_reg     <= 10'h0;
			blink_reg_q   <= 1'b0;
		end else begin
			st_reg       <= st_next;
			eff_prev_reg <= eff;
			if (tick_reg) begin
				if ({22'h0, blink_reg} == BLINK_LAST) begin
					blink_reg   <= 10'h0;
					blink_reg_q <= ~blink_reg_q;
				end else
					blink_reg <= blink_reg + 10'h1;
			end
			if (st_next != st_reg) begin
				tmr_reg  <= 32'h0;
				step_reg <= 4'h0;
			end else if (tick_reg) begin
				if ((st_reg == S_FLASH && tmr_reg == `CMS_FLASH_HALF_MS - 1) ||
				    (st_reg == S_SCAN && tmr_reg == `CMS_SCAN_STEP_MS - 1)) begin
					tmr_reg  <= 32'h0;
					step_reg <= step_reg + 4'h1;
				end else
					tmr_reg <= tmr_reg + 32'h1;
			end
			if (st_reg == S_SCAN && st_next == S_DONE) begin
				tog_armed_reg <= 1'b1;
				tog_reg       <= 32'h0;
				mode_tmr_reg  <= 32'h0;
				if (eff == `CMS_SEL_ON && step_reg == 4'h0)
					mode_reg <= `CMS_MODE_EQ;
				else if (eff == `CMS_SEL_ON && step_reg == 4'h1)
					mode_reg <= `CMS_MODE_FABS;
				else
					mode_reg <= `CMS_MODE_FLOAT;
			end else begin
				if (tick_reg && tog_armed_reg) begin
					if (tog_reg == `CMS_TOGGLE_MAX_MS)
						tog_armed_reg <= 1'b0;
					else
						tog_reg <= tog_reg + 32'h1;
				end
				// one quick correction toggle is absorbed, mode kept
				if (tog_armed_reg && eff != eff_prev_reg && eff != `CMS_SEL_OFF)
					tog_armed_reg <= 1'b0;
				if (tick_reg && (mode_reg == `CMS_MODE_EQ || mode_reg == `CMS_MODE_FABS)) begin
					if ((mode_reg == `CMS_MODE_EQ && mode_tmr_reg == EQ_MS - 1) ||
					    (mode_reg == `CMS_MODE_FABS && mode_tmr_reg == ABS_MAX_MS - 1))
						mode_reg <= `CMS_MODE_FLOAT;
					else
						mode_reg <= mode_reg;
					mode_tmr_reg <= mode_tmr_reg + 32'h1;
				end
				if (!mains_ok_i || eff == `CMS_SEL_OFF)
					mode_reg <= `CMS_MODE_NORMAL;
			end
		end
	end

	// power path and lights, all registered
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			power_en_o        <= 1'b0;
			inverter_en_o     <= 1'b0;
			pass_through_o    <= 1'b0;
			charger_en_o      <= 1'b0;
			charge_mode_o     <= `CMS_MODE_NORMAL;
			target_raise_v_o  <= 2'h0;
			current_quarter_o <= 1'b0;
			current_zero_o    <= 1'b0;
			led_inverter_o    <= 1'b0;
			led_mains_o       <= 1'b0;
			led_bulk_o        <= 1'b0;
			led_abs_o         <= 1'b0;
			led_float_o       <= 1'b0;
		end else begin
			// during the sequence the inverter is held off, even while the switch is back in on
			power_en_o        <= (eff != `CMS_SEL_OFF);
			inverter_en_o     <= (eff == `CMS_SEL_ON) && !mains_ok_i && st_reg == S_IDLE;
			pass_through_o    <= (eff != `CMS_SEL_OFF) && mains_ok_i;
			charger_en_o      <= (eff != `CMS_SEL_OFF) && mains_ok_i;
			charge_mode_o     <= mode_reg;
			target_raise_v_o  <= (mode_reg == `CMS_MODE_EQ) ? (batt_24v_i ? 2'h2 : 2'h1) : 2'h0;
			current_quarter_o <= (mode_reg == `CMS_MODE_EQ);
			current_zero_o    <= mains_ok_i && in_limit_i;
			led_inverter_o    <= (eff == `CMS_SEL_ON) && !mains_ok_i && st_reg == S_IDLE;
			led_mains_o       <= mains_ok_i && (in_limit_i ? blink_reg_q : 1'b1);
			if (st_reg == S_FLASH) begin
				led_bulk_o  <= flash_lit;
				led_abs_o   <= flash_lit;
				led_float_o <= flash_lit;
			end else if (st_reg == S_SCAN) begin
				led_bulk_o  <= (step_reg == 4'h0);
				led_abs_o   <= (step_reg == 4'h1);
				led_float_o <= (step_reg == 4'h2);
			end else if (!mains_ok_i || eff == `CMS_SEL_OFF) begin
				led_bulk_o  <= 1'b0;
				led_abs_o   <= 1'b0;
				led_float_o <= 1'b0;
			end else if (mode_reg == `CMS_MODE_EQ) begin
				led_bulk_o  <= blink_reg_q;
				led_abs_o   <= blink_reg_q;
				led_float_o <= 1'b0;
			end else if (mode_reg == `CMS_MODE_FABS) begin
				led_bulk_o  <= 1'b0;
				led_abs_o   <= 1'b1;
				led_float_o <= 1'b0;
			end else if (mode_reg == `CMS_MODE_FLOAT) begin
				led_bulk_o  <= 1'b0;
				led_abs_o   <= 1'b0;
				led_float_o <= 1'b1;
			end else begin
				led_bulk_o  <= (charge_phase_i == `CMS_PH_BULK);
				led_abs_o   <= (charge_phase_i == `CMS_PH_ABS) ||
				               (charge_phase_i == `CMS_PH_BULK && ramp_limited_i);
				led_float_o <= (charge_phase_i == `CMS_PH_FLOAT);
			end
		end
	end
endmodule
`default_nettype wire

// [dv/cms_switch_model.sv]
// front and remote selector panel worked by a person
// assumes MS_CYC bench clocks per millisecond
`timescale 1ns/10ps
`default_nettype none
module cms_switch_model #(
	parameter int MS_CYC = 2
) (
	input  wire logic       ref_clk_i,
	output var  logic [1:0] front_sel_o,
	output var  logic [1:0] remote_sel_o,
	output var  logic       remote_present_o
);
	initial begin
		front_sel_o = 2'h1;
		remote_sel_o = 2'h1;
		remote_present_o = 1'b0;
	end
	// jumps straight between positions, rests in off only when asked
	task automatic move(input logic [1:0] pos, input int ms);
		@(posedge ref_clk_i);
		#1 front_sel_o = pos;
		repeat (ms * MS_CYC) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic remote(input logic p, input logic [1:0] pos);
		remote_present_o = p;
		remote_sel_o = pos;
	endtask
	// only started by the bench with the charger in float
	task automatic select_seq(input int hold_ms);
		move(2'h2, hold_ms);
		move(2'h1, hold_ms);
		move(2'h2, 0);
	endtask
endmodule
`default_nettype wire

// [dv/cms_sequencer_monitor.sv]
// output relations of the sequencer
// assumes inputs move just after the clock edge
`timescale 1ns/10ps
`default_nettype none
`include "cms_defines.vh"
module cms_sequencer_monitor (
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	input wire logic       mains_ok_i,
	input wire logic [1:0] charge_phase_i,
	input wire logic       ramp_limited_i,
	input wire logic       in_limit_i,
	input wire logic       batt_24v_i,
	input wire logic       inverter_en_o,
	input wire logic       pass_through_o,
	input wire logic [1:0] charge_mode_o,
	input wire logic [1:0] target_raise_v_o,
	input wire logic       current_quarter_o,
	input wire logic       current_zero_o,
	input wire logic       led_inverter_o,
	input wire logic       led_bulk_o,
	input wire logic       led_abs_o,
	input wire logic       led_float_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// two cycles so registered lights have caught up
	sequence s_mode(logic [1:0] m);
		(charge_mode_o == m) [*2];
	endsequence
	sequence s_steady(logic r);
		(pass_through_o && charge_mode_o == `CMS_MODE_NORMAL && charge_phase_i == `CMS_PH_BULK
			&& !in_limit_i && ramp_limited_i == r) [*3];
	endsequence
	a_inv_led_on: assert property (inverter_en_o |-> led_inverter_o)
		else $error("inverter runs with its light off");
	a_pass_inv_off: assert property (pass_through_o |-> !inverter_en_o)
		else $error("inverter runs during pass-through");
	a_no_mains_open: assert property ((!mains_ok_i) [*3] |-> !pass_through_o)
		else $error("pass-through without mains");
	a_eq_raise_v: assert property (s_mode(`CMS_MODE_EQ) |-> target_raise_v_o == ($past(batt_24v_i) ? 2'h2 : 2'h1))
		else $error("wrong equalise voltage raise");
	a_eq_quarter: assert property (s_mode(`CMS_MODE_EQ) |-> current_quarter_o)
		else $error("equalise current not limited");
	a_eq_blink_pair: assert property (s_mode(`CMS_MODE_EQ) |-> led_bulk_o == led_abs_o && !led_float_o)
		else $error("equalise lights not paired");
	a_fabs_abs_led: assert property (s_mode(`CMS_MODE_FABS) |-> led_abs_o && !led_bulk_o && !led_float_o)
		else $error("forced absorption light wrong");
	a_trio_flash: assert property ($rose(led_float_o) && led_bulk_o |-> led_abs_o)
		else $error("flash without absorption light");
	a_phase_led: assert property (s_steady(1'b0) |-> led_bulk_o && !led_abs_o && !led_float_o)
		else $error("bulk phase lights wrong");
	a_ramp_led: assert property (s_steady(1'b1) |-> led_bulk_o && led_abs_o && !led_float_o)
		else $error("ramp limited lights wrong");
	a_limit_zero: assert property ((mains_ok_i && in_limit_i) [*3] |-> current_zero_o)
		else $error("charge current not cut at limit");
endmodule
`default_nettype wire

// [dv/charge_mode_switch_sequencer_tb.sv]
// bench for the charge mode switch sequencer
// assumes a 2-cycle tick so a millisecond is two clocks
`timescale 1ns/10ps
`default_nettype none
`include "cms_defines.vh"
module charge_mode_switch_sequencer_tb;
	localparam int MS = 2;
	logic       ref_clk_i, rst_n_i, mains_ok_i, ramp_limited_i, in_limit_i, rp, b24;
	logic [1:0] phase, mode, raise, fs, rs;
	logic       pwr, inv, pass, chg, quart, zero, l_inv, l_mains, l_bulk, l_abs, l_float;
	int         fails = 0;
	int         total_checks = 0;
	cms_switch_model i_sw (.ref_clk_i(ref_clk_i), .front_sel_o(fs), .remote_sel_o(rs),
		.remote_present_o(rp));
	cms_sequencer #(.TICK_CYC(MS), .EQ_MS(200), .ABS_MAX_MS(200)) i_dut (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .front_sel_i(fs), .remote_sel_i(rs), .remote_present_i(rp),
		.mains_ok_i(mains_ok_i), .charge_phase_i(phase), .ramp_limited_i(ramp_limited_i),
		.in_limit_i(in_limit_i), .batt_24v_i(b24), .power_en_o(pwr), .inverter_en_o(inv),
		.pass_through_o(pass), .charger_en_o(chg), .charge_mode_o(mode), .target_raise_v_o(raise),
		.current_quarter_o(quart), .current_zero_o(zero), .led_inverter_o(l_inv), .led_mains_o(l_mains),
		.led_bulk_o(l_bulk), .led_abs_o(l_abs), .led_float_o(l_float));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// counts trio flashes; returns once the scan lights bulk alone
	task automatic to_scan(output int n);
		logic prev;
		n = 0;
		prev = 1'b0;
		for (int i = 0; i < 4000 * MS && !(l_bulk && !l_float && n > 0); i++) begin
			cyc(1);
			n += (l_bulk && !prev && l_float && l_abs);
			prev = l_bulk;
		end
	endtask
	task automatic t_power;
		int n;
		logic prev;
		mains_ok_i = 0;
		cyc(4);
		check("inverter", {pwr, inv, l_inv, pass}, 4'b1110);
		mains_ok_i = 1;
		phase = `CMS_PH_BULK;
		cyc(4);
		check("bulk", {inv, pass, chg, l_mains, l_bulk, l_abs, l_float}, 7'b0111100);
		ramp_limited_i = 1;
		cyc(4);
		check("ramp", {l_bulk, l_abs, l_float}, 3'b110);
		ramp_limited_i = 0;
		in_limit_i = 1;
		n = 0;
		for (int i = 0; i < 1200 * MS; i++) begin
			prev = l_mains;
			cyc(1);
			n += (l_mains != prev);
		end
		check("limit", {zero, n > 1}, 2'b11);
		in_limit_i = 0;
		phase = `CMS_PH_FLOAT;
		i_sw.move(2'h2, 100);
		mains_ok_i = 0;
		cyc(8);
		check("chg only dry", {inv, pass, chg}, 3'b000);
		mains_ok_i = 1;
		cyc(4);
		check("chg only wet", {inv, pass, chg}, 3'b011);
		i_sw.move(2'h1, 100);
		$display("t_power done");
	endtask
	// a remote parked in charger-only, then a too short hold
	task automatic t_refuse;
		int n;
		i_sw.remote(1'b1, 2'h2);
		i_sw.select_seq(700);
		to_scan(n);
		check("remote chg", n, 0);
		i_sw.remote(1'b1, 2'h1);
		i_sw.move(2'h1, 100);
		i_sw.move(2'h2, 200);
		i_sw.move(2'h1, 700);
		i_sw.move(2'h2, 0);
		to_scan(n);
		check("short hold", n, 0);
		i_sw.move(2'h1, 100);
		i_sw.move(2'h2, 700);
		i_sw.move(2'h0, 5);
		check("off blip", {pwr, inv, chg}, 3'b000);
		i_sw.move(2'h1, 700);
		i_sw.move(2'h2, 0);
		to_scan(n);
		check("off restart", n, 0);
		i_sw.move(2'h1, 100);
		$display("t_refuse done");
	endtask
	task automatic t_float;
		int n;
		i_sw.select_seq(700);
		to_scan(n);
		check("flashes", n, 5);
		cyc(6500 * MS);
		check("no move", {mode, inv, chg, pass}, {`CMS_MODE_FLOAT, 3'b011});
		i_sw.move(2'h1, 300);
		check("toggle", mode, `CMS_MODE_FLOAT);
		$display("t_float done");
	endtask
	task automatic t_eq;
		int n;
		i_sw.select_seq(700);
		to_scan(n);
		i_sw.move(2'h1, 100);
		check("eq", {mode, raise, quart, l_mains}, {`CMS_MODE_EQ, 2'h2, 2'b11});
		b24 = 0;
		cyc(2);
		check("eq 12v", raise, 2'h1);
		i_sw.move(2'h2, 40);
		check("eq kept", {mode, l_bulk ^ l_abs}, {`CMS_MODE_EQ, 1'b0});
		cyc(150 * MS);
		check("eq end", mode, `CMS_MODE_FLOAT);
		i_sw.move(2'h1, 100);
		$display("t_eq done");
	endtask
	task automatic t_fabs;
		int n;
		i_sw.select_seq(700);
		to_scan(n);
		check("scan bulk", {l_bulk, l_abs, l_float}, 3'b100);
		cyc(2100 * MS);
		check("scan abs", {l_bulk, l_abs, l_float}, 3'b010);
		i_sw.move(2'h1, 100);
		check("fabs", mode, `CMS_MODE_FABS);
		cyc(200 * MS);
		check("fabs end", mode, `CMS_MODE_FLOAT);
		$display("t_fabs done");
	endtask
	initial begin
		ref_clk_i = 0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// whole run needs about 81k clocks
	initial begin
		repeat (97000) @(posedge ref_clk_i);
		fails++;
		finish_test;
	end
	initial begin
		{rst_n_i, mains_ok_i, ramp_limited_i, in_limit_i, b24} = 5'h01;
		phase = `CMS_PH_FLOAT;
		repeat (12) @(posedge ref_clk_i);
		#1 rst_n_i = 1;
		cyc(100 * MS);
		t_power;
		t_refuse;
		t_float;
		t_eq;
		t_fabs;
		finish_test;
	end
endmodule
bind cms_sequencer cms_sequencer_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.mains_ok_i(mains_ok_i), .charge_phase_i(charge_phase_i), .ramp_limited_i(ramp_limited_i),
	.in_limit_i(in_limit_i), .batt_24v_i(batt_24v_i), .inverter_en_o(inverter_en_o),
	.pass_through_o(pass_through_o), .charge_mode_o(charge_mode_o), .target_raise_v_o(target_raise_v_o),
	.current_quarter_o(current_quarter_o), .current_zero_o(current_zero_o), .led_inverter_o(led_inverter_o),
	.led_bulk_o(led_bulk_o), .led_abs_o(led_abs_o), .led_float_o(led_float_o));
`default_nettype wire
